// ### design/pmd_top.sv
// APB slave holding the module disable registers and driving per-module gate and reset outputs
`timescale 1ns/1ps
module pmd_top
	import pmd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic periph_sysclk_off,
	output logic vref_off,
	output logic eeprom_access_off,
	output logic refclk_out_off,
	output logic pin_change_irq_off,
	output logic num_osc_off,
	output logic [6:0] timer_off,
	output logic dtoa_off,
	output logic atod_off,
	output logic comparator_one_off,
	output logic comparator_two_off,
	input wire logic nvm_rd_req,
	input wire logic nvm_wr_req,
	input wire logic memctl_wr_req,
	input wire logic ind_ptr_eeprom,
	input wire logic [7:0] nvm_rd_data_in,
	output logic nvm_rd_gnt,
	output logic nvm_wr_gnt,
	output logic memctl_wr_gnt,
	output logic [7:0] nvm_rd_data_out,
	output logic nvm_wake_busy
);
	// Selecting a word by address, used by both read and write paths
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	logic [7:0] sys_val;
	logic [7:0] tmr_val;
	logic [7:0] ana_val;
	logic wr_access;
	logic wr_lane0;
	logic sel_sys;
	logic sel_tmr;
	logic sel_ana;
	logic sel_stat;
	logic mapped;
	logic [7:0] stat_val;
	logic [7:0] rd_mux;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic setup;
	logic [7:0] sys_out_reg;
	logic [7:0] tmr_out_reg;
	logic [7:0] ana_out_reg;
	logic [7:0] nvm_rd_data_reg;
	logic [7:0] nvm_rd_data_next;

	// Address decode; byte lane 0 carries the eight disable bits
	assign sel_sys = hit(paddr, PMD_OFS_SYS);
	assign sel_tmr = hit(paddr, PMD_OFS_TMR);
	assign sel_ana = hit(paddr, PMD_OFS_ANA);
	assign sel_stat = hit(paddr, PMD_OFS_STAT);
	assign mapped = sel_sys | sel_tmr | sel_ana | sel_stat;
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite && mapped;
	assign wr_lane0 = wr_access && pstrb[0];

	// Registers hold software intent; masks drop unimplemented bits
	pmd_regbit #(.MASK(PMD_SYS_MASK)) u_sys (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(wr_lane0 && sel_sys),
		.wr_data(pwdata[7:0]),
		.value(sys_val)
	);
	pmd_regbit #(.MASK(PMD_TMR_MASK)) u_tmr (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(wr_lane0 && sel_tmr),
		.wr_data(pwdata[7:0]),
		.value(tmr_val)
	);
	pmd_regbit #(.MASK(PMD_ANA_MASK)) u_ana (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(wr_lane0 && sel_ana),
		.wr_data(pwdata[7:0]),
		.value(ana_val)
	);

	// Settle window after EEPROM access comes back, reported as status
	pmd_wake #(.CYCLES(PMD_NVM_WAKE_CYC)) u_wake (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.off(eeprom_access_off),
		.busy(nvm_wake_busy)
	);

	// Status word: bit 0 shows that EEPROM is still settling
	assign stat_val = {7'h00, nvm_wake_busy};

	// Read mux; unmapped words read zero and flag an error
	assign rd_mux = sel_sys ? sys_val :
		sel_tmr ? tmr_val :
		sel_ana ? ana_val :
		sel_stat ? stat_val : 8'h00;
	assign prdata_next = setup ? {24'h000000, rd_mux} : prdata_reg;
	assign pslverr_next = setup ? !mapped : pslverr_reg;

	// Read data is latched in setup so the access phase sees a stable word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// Zero wait states: every access phase completes at once
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = psel && penable && pslverr_reg;

	// Output stage registered once more so gates never see a decode glitch
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_out_reg <= PMD_RST_VAL;
			tmr_out_reg <= PMD_RST_VAL;
			ana_out_reg <= PMD_RST_VAL;
		end else begin
			sys_out_reg <= sys_val;
			tmr_out_reg <= tmr_val;
			ana_out_reg <= ana_val;
		end
	end

	// Per-module disable lines; each acts as clock gate and held reset at the module
	assign periph_sysclk_off = sys_out_reg[PMD_BIT_SYSCLK];
	assign vref_off = sys_out_reg[PMD_BIT_VREF];
	assign eeprom_access_off = sys_out_reg[PMD_BIT_EEPROM];
	assign refclk_out_off = sys_out_reg[PMD_BIT_REFCLK];
	assign pin_change_irq_off = sys_out_reg[PMD_BIT_PINCHG];
	assign num_osc_off = tmr_out_reg[PMD_BIT_NCO];
	assign timer_off = tmr_out_reg[6:0];
	assign dtoa_off = ana_out_reg[PMD_BIT_DAC];
	assign atod_off = ana_out_reg[PMD_BIT_ADC];
	assign comparator_two_off = ana_out_reg[PMD_BIT_CMP2];
	assign comparator_one_off = ana_out_reg[PMD_BIT_CMP1];

	// EEPROM gate: requests are only granted while access is on
	assign nvm_rd_gnt = nvm_rd_req && !eeprom_access_off;
	assign nvm_wr_gnt = nvm_wr_req && !eeprom_access_off;
	assign memctl_wr_gnt = memctl_wr_req && !eeprom_access_off;

	// Returned EEPROM data is forced to zero while access is off
	assign nvm_rd_data_next = (eeprom_access_off || !nvm_rd_req) ? 8'h00 :
		(ind_ptr_eeprom || nvm_rd_req ? nvm_rd_data_in : 8'h00);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_rd_data_reg <= 8'h00;
		end else begin
			nvm_rd_data_reg <= nvm_rd_data_next;
		end
	end
	assign nvm_rd_data_out = nvm_rd_data_reg;

	// Checks tying outputs to register state and the bus protocol
	property p_sysclk_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_sys) |=> ##1 periph_sysclk_off == $past(pwdata[7], 2);
	endproperty
	a_sysclk_follow: assert property (p_sysclk_follow) else $error("sysclk gate wrong");

	property p_vref_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_sys) |-> ##2 vref_off == $past(pwdata[6], 2);
	endproperty
	a_vref_follow: assert property (p_vref_follow) else $error("vref gate wrong");

	property p_nvm_block;
		@(posedge sys_clk) disable iff (!rst_n)
		eeprom_access_off |-> !nvm_rd_gnt && !nvm_wr_gnt && !memctl_wr_gnt;
	endproperty
	a_nvm_block: assert property (p_nvm_block) else $error("eeprom not blocked");

	property p_ind_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		(eeprom_access_off && ind_ptr_eeprom) |=> nvm_rd_data_out == 8'h00;
	endproperty
	a_ind_zero: assert property (p_ind_zero) else $error("eeprom read not zero");

	property p_timer_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_tmr) |-> ##2 timer_off == $past(pwdata[6:0], 2);
	endproperty
	a_timer_follow: assert property (p_timer_follow) else $error("timer gate wrong");

	property p_nco_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_tmr) |-> ##2 num_osc_off == $past(pwdata[7], 2);
	endproperty
	a_nco_follow: assert property (p_nco_follow) else $error("nco gate wrong");

	property p_ana_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_ana) |-> ##2 (dtoa_off == $past(pwdata[6], 2)) &&
			(atod_off == $past(pwdata[5], 2)) && (comparator_one_off == $past(pwdata[1], 2));
	endproperty
	a_ana_follow: assert property (p_ana_follow) else $error("analog gate wrong");

	property p_ana_unused;
		@(posedge sys_clk) disable iff (!rst_n)
		(setup && sel_ana) |=> (prdata[7] == 1'b0) && (prdata[4:3] == 2'b00) && !prdata[0];
	endproperty
	a_ana_unused: assert property (p_ana_unused) else $error("unused bit read high");

	property p_stable_out;
		@(posedge sys_clk) disable iff (!rst_n)
		!(wr_lane0) ##1 !(wr_lane0) |=> $stable(sys_out_reg);
	endproperty
	a_stable_out: assert property (p_stable_out) else $error("gate moved without write");

	property p_refclk_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_sys) |-> ##2 refclk_out_off == $past(pwdata[1], 2);
	endproperty
	a_refclk_follow: assert property (p_refclk_follow) else $error("refclk gate wrong");

	property p_pinchg_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_sys) |-> ##2 pin_change_irq_off == $past(pwdata[0], 2);
	endproperty
	a_pinchg_follow: assert property (p_pinchg_follow) else $error("pin change gate wrong");

	property p_eeprom_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_sys) |-> ##2 eeprom_access_off == $past(pwdata[2], 2);
	endproperty
	a_eeprom_follow: assert property (p_eeprom_follow) else $error("eeprom gate wrong");

	property p_cmp_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_lane0 && sel_ana) |-> ##2 (comparator_two_off == $past(pwdata[2], 2)) &&
			(comparator_one_off == $past(pwdata[1], 2));
	endproperty
	a_cmp_follow: assert property (p_cmp_follow) else $error("comparator gate wrong");

	// Unused system bits and the upper word must always read low
	property p_sys_unused;
		@(posedge sys_clk) disable iff (!rst_n)
		(setup && sel_sys) |=> prdata[5:3] == 3'b000;
	endproperty
	a_sys_unused: assert property (p_sys_unused) else $error("unused system bit read high");

	property p_rd_upper;
		@(posedge sys_clk) disable iff (!rst_n)
		setup |=> prdata[31:8] == 24'h000000;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits high");

	property p_slverr_map;
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable) |-> pslverr == !mapped;
	endproperty
	a_slverr_map: assert property (p_slverr_map) else $error("error flag wrong");

	// A write without byte lane 0 must leave every register untouched
	property p_lane0_guard;
		@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable && pwrite && !pstrb[0]) |=>
			$stable(sys_val) && $stable(tmr_val) && $stable(ana_val);
	endproperty
	a_lane0_guard: assert property (p_lane0_guard) else $error("write without lane 0 landed");

	property p_grant_open;
		@(posedge sys_clk) disable iff (!rst_n)
		!eeprom_access_off |-> (nvm_rd_gnt == nvm_rd_req) && (nvm_wr_gnt == nvm_wr_req) &&
			(memctl_wr_gnt == memctl_wr_req);
	endproperty
	a_grant_open: assert property (p_grant_open) else $error("eeprom grant lost");

	property p_nvm_data_on;
		@(posedge sys_clk) disable iff (!rst_n)
		(!eeprom_access_off && nvm_rd_req) |=> nvm_rd_data_out == $past(nvm_rd_data_in);
	endproperty
	a_nvm_data_on: assert property (p_nvm_data_on) else $error("eeprom data lost");

	property p_wake_status;
		@(posedge sys_clk) disable iff (!rst_n)
		(setup && sel_stat) |=> prdata == {31'h00000000, $past(nvm_wake_busy)};
	endproperty
	a_wake_status: assert property (p_wake_status) else $error("status word wrong");

	// The output stage is exactly one register behind the software copy
	property p_out_stage;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> {sys_out_reg, tmr_out_reg, ana_out_reg} == $past({sys_val, tmr_val, ana_val});
	endproperty
	a_out_stage: assert property (p_out_stage) else $error("output stage lagging");

	property p_stable_tmr;
		@(posedge sys_clk) disable iff (!rst_n)
		!(wr_lane0 && sel_tmr) |=> ##1 $stable(tmr_out_reg);
	endproperty
	a_stable_tmr: assert property (p_stable_tmr) else $error("timer gate moved");

	property p_stable_ana;
		@(posedge sys_clk) disable iff (!rst_n)
		!(wr_lane0 && sel_ana) |=> ##1 $stable(ana_out_reg);
	endproperty
	a_stable_ana: assert property (p_stable_ana) else $error("analog gate moved");
endmodule

// ### design/pmd_pkg.sv
// Package of offsets, field positions and reset values for the peripheral module disable block
// Overview of operation
// - Bit 7 of the system register, when set, stops the system clock to the peripheral clock network.
// - Bit 6 of the system register, when set, disables the fixed voltage reference.
// - Bit 2 of the system register, when set, blocks data EEPROM reads and writes and memory control writes.
// - While EEPROM access is off, an indirect-pointer access to EEPROM space returns zero.
// - Bit 1 of the system register, when set, disables the reference clock output.
// - Bit 0 of the system register, when set, disables pin-change detection on all ports.
// - Unimplemented bits of the disable registers read as zero and ignore writes.
// - Bit 7 of the timer register, when set, disables the numerically controlled oscillator.
// - Bits 6 to 0 of the timer register, when set, disable timers 6 to 0.
// - Bits 6 and 5 of the analog register disable the DAC and the ADC.
// - Bits 2 and 1 of the analog register disable comparators 2 and 1; other bits are unused.
// - Every implemented bit is read/write and clears on any reset.
// - A disabled module has its clock stopped, is held in reset, ignores writes and reads zero.
// - A re-enabled module restarts from reset values and is left alone for one instruction cycle.
package pmd_pkg;
	localparam logic [11:0] PMD_OFS_SYS = 12'h000;
	localparam logic [11:0] PMD_OFS_TMR = 12'h004;
	localparam logic [11:0] PMD_OFS_ANA = 12'h008;
	localparam logic [11:0] PMD_OFS_STAT = 12'h00C;
	localparam logic [7:0] PMD_SYS_MASK = 8'hC7;
	localparam logic [7:0] PMD_TMR_MASK = 8'hFF;
	localparam logic [7:0] PMD_ANA_MASK = 8'h66;
	localparam logic [7:0] PMD_RST_VAL = 8'h00;
	localparam int PMD_BIT_SYSCLK = 7;
	localparam int PMD_BIT_VREF = 6;
	localparam int PMD_BIT_EEPROM = 2;
	localparam int PMD_BIT_REFCLK = 1;
	localparam int PMD_BIT_PINCHG = 0;
	localparam int PMD_BIT_NCO = 7;
	localparam int PMD_BIT_DAC = 6;
	localparam int PMD_BIT_ADC = 5;
	localparam int PMD_BIT_CMP2 = 2;
	localparam int PMD_BIT_CMP1 = 1;
	localparam int PMD_CLK_MHZ = 20;
	localparam int PMD_NVM_WAKE_NS = 1000;
	localparam int PMD_NVM_WAKE_CYC = (PMD_NVM_WAKE_NS * PMD_CLK_MHZ + 999) / 1000;
	localparam int PMD_RESTART_CYC = 1;
endpackage

// ### design/pmd_regbit.sv
// Single masked disable register with reset-to-zero behaviour
`timescale 1ns/1ps
module pmd_regbit
	import pmd_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;

	// Unused positions are forced low so they never store anything
	assign value_next = wr_en ? (wr_data & MASK) : value_reg;
	assign value = value_reg;

	// Clears on any reset so every module starts enabled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			value_reg <= PMD_RST_VAL;
		end else begin
			value_reg <= value_next;
		end
	end

	// Masked positions must never hold a one, whatever software writes
	property p_unused_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		(value_reg & ~MASK) == 8'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

	property p_write_lands;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_en |=> value_reg == ($past(wr_data) & MASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write lost");
endmodule

// ### design/pmd_wake.sv
// Countdown that reports when a re-enabled module may be touched again
`timescale 1ns/1ps
module pmd_wake
	import pmd_pkg::*;
#(
	parameter int CYCLES = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic off,
	output logic busy
);
	logic off_reg;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic reenable;

	// A falling disable starts the settle window
	assign reenable = off_reg && !off;
	assign cnt_next = reenable ? 8'(CYCLES) : (cnt_reg != 8'h00 ? cnt_reg - 8'h01 : 8'h00);
	assign busy = cnt_reg != 8'h00;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			off_reg <= 1'b0;
			cnt_reg <= 8'h00;
		end else begin
			off_reg <= off;
			cnt_reg <= cnt_next;
		end
	end

	// A re-enable must always open the window, or software could touch a cold module
	property p_wake_start;
		@(posedge sys_clk) disable iff (!rst_n)
		reenable |=> busy;
	endproperty
	a_wake_start: assert property (p_wake_start) else $error("settle window missing");
endmodule

// ### test/pmd_periph_model.sv
// Behavioural model of the data memory that answers granted reads
`timescale 1ns/1ps
module pmd_periph_model #(
	parameter logic [7:0] MEM_BYTE = 8'hA5
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic nvm_rd_gnt,
	input wire logic eeprom_access_off,
	output logic [7:0] nvm_rd_data_in
);
	logic [7:0] last_reg;
	// Remember what was on the bus so a released bus never repeats it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) last_reg <= 8'h00;
		else last_reg <= nvm_rd_data_in;
	end
	// A disabled memory drives nothing; the floating bus shows the inverse
	assign nvm_rd_data_in = (nvm_rd_gnt && !eeprom_access_off) ? MEM_BYTE : ~last_reg;
endmodule

// ### test/tb_pmd_top.sv
// Testbench for the peripheral module disable register block
`timescale 1ns/1ps
module tb_pmd_top
	import pmd_pkg::*;
;
	logic sys_clk, rst_n, psel, penable, pwrite, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic periph_sysclk_off, vref_off, eeprom_access_off, refclk_out_off, pin_change_irq_off;
	logic num_osc_off, dtoa_off, atod_off, comparator_one_off, comparator_two_off;
	logic [6:0] timer_off;
	logic nvm_rd_req, nvm_wr_req, memctl_wr_req, ind_ptr_eeprom;
	logic nvm_rd_gnt, nvm_wr_gnt, memctl_wr_gnt, nvm_wake_busy, er;
	logic [7:0] nvm_rd_data_in, nvm_rd_data_out;
	int err_total = 0;
	int n_checks = 0;
	logic [11:0] ofs [3];
	logic [7:0] msk [3];

	pmd_top i_pmd_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .periph_sysclk_off(periph_sysclk_off),
		.vref_off(vref_off), .eeprom_access_off(eeprom_access_off),
		.refclk_out_off(refclk_out_off), .pin_change_irq_off(pin_change_irq_off),
		.num_osc_off(num_osc_off), .timer_off(timer_off), .dtoa_off(dtoa_off),
		.atod_off(atod_off), .comparator_one_off(comparator_one_off),
		.comparator_two_off(comparator_two_off), .nvm_rd_req(nvm_rd_req),
		.nvm_wr_req(nvm_wr_req), .memctl_wr_req(memctl_wr_req),
		.ind_ptr_eeprom(ind_ptr_eeprom), .nvm_rd_data_in(nvm_rd_data_in),
		.nvm_rd_gnt(nvm_rd_gnt), .nvm_wr_gnt(nvm_wr_gnt), .memctl_wr_gnt(memctl_wr_gnt),
		.nvm_rd_data_out(nvm_rd_data_out), .nvm_wake_busy(nvm_wake_busy));

	pmd_periph_model i_pmd_periph_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.nvm_rd_gnt(nvm_rd_gnt), .eeprom_access_off(eeprom_access_off),
		.nvm_rd_data_in(nvm_rd_data_in));

	// Free running 50 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			wrap_up();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Let the output stage settle after a write
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic [7:0] outv(input int r);
		if (r == 0) return {periph_sysclk_off, vref_off, 3'b000, eeprom_access_off,
			refclk_out_off, pin_change_irq_off};
		if (r == 1) return {num_osc_off, timer_off};
		return {1'b0, dtoa_off, atod_off, 2'b00, comparator_two_off, comparator_one_off, 1'b0};
	endfunction

	initial begin
		int n;
		ofs = '{PMD_OFS_SYS, PMD_OFS_TMR, PMD_OFS_ANA};
		msk = '{PMD_SYS_MASK, PMD_TMR_MASK, PMD_ANA_MASK};
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{nvm_rd_req, nvm_wr_req, memctl_wr_req, ind_ptr_eeprom} = 4'h0;
		rst_n = 1'b0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Everything starts enabled
		for (int r = 0; r < 3; r++) begin
			apb(1'b0, ofs[r], 32'h0, 4'hF, rd, er);
			chk("reset value", rd, 32'h0);
			chk("reset outputs", {24'h0, outv(r)}, 32'h0);
		end
		$display("test reset done");
		// Walk a one through every bit of every disable register
		for (int r = 0; r < 3; r++) begin
			for (int b = 0; b < 8; b++) begin
				apb(1'b1, ofs[r], 32'hFFFF_FF00 | (32'h1 << b), 4'hF, rd, er);
				settle();
				chk("disable line", {24'h0, outv(r)}, {24'h0, msk[r] & (8'h01 << b)});
				apb(1'b0, ofs[r], 32'h0, 4'hF, rd, er);
				chk("readback", rd, {24'h0, msk[r] & (8'h01 << b)});
			end
			apb(1'b1, ofs[r], 32'h0, 4'hF, rd, er);
		end
		$display("test bit map done");
		// Unmapped word and a write without lane 0
		apb(1'b1, 12'h010, 32'hFF, 4'hF, rd, er);
		chk("unmapped write err", {31'h0, er}, 32'h1);
		apb(1'b0, 12'h010, 32'h0, 4'hF, rd, er);
		chk("unmapped read", rd, 32'h0);
		chk("unmapped read err", {31'h0, er}, 32'h1);
		apb(1'b1, PMD_OFS_TMR, 32'hFF, 4'hE, rd, er);
		apb(1'b0, PMD_OFS_TMR, 32'h0, 4'hF, rd, er);
		chk("lane0 off write", rd, 32'h0);
		$display("test refusals done");
		// Memory access blocked while disabled
		apb(1'b1, PMD_OFS_SYS, 32'h04, 4'hF, rd, er);
		settle();
		@(posedge sys_clk);
		{nvm_rd_req, nvm_wr_req, memctl_wr_req, ind_ptr_eeprom} <= 4'hF;
		settle();
		chk("grants", {29'h0, nvm_rd_gnt, nvm_wr_gnt, memctl_wr_gnt}, 32'h0);
		chk("pointer read", {24'h0, nvm_rd_data_out}, 32'h0);
		@(posedge sys_clk);
		{nvm_rd_req, nvm_wr_req, memctl_wr_req, ind_ptr_eeprom} <= 4'h0;
		apb(1'b1, PMD_OFS_SYS, 32'h0, 4'hF, rd, er);
		n = 0;
		while (nvm_wake_busy !== 1'b1 && n < 10) begin
			@(posedge sys_clk);
			n++;
		end
		chk("wake busy", {31'h0, nvm_wake_busy}, 32'h1);
		apb(1'b0, PMD_OFS_STAT, 32'h0, 4'hF, rd, er);
		chk("status busy", rd, 32'h1);
		n = 0;
		while (nvm_wake_busy !== 1'b0 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 100) begin
			err_total++;
			wrap_up();
		end
		// Access only once the settle window is over
		@(posedge sys_clk);
		{nvm_rd_req, nvm_wr_req, memctl_wr_req} <= 3'h7;
		settle();
		chk("enabled read", {23'h0, nvm_rd_gnt, nvm_rd_data_out}, 32'h1A5);
		chk("grants on", {29'h0, nvm_rd_gnt, nvm_wr_gnt, memctl_wr_gnt}, 32'h7);
		@(posedge sys_clk);
		{nvm_rd_req, nvm_wr_req, memctl_wr_req} <= 3'h0;
		$display("test memory done");
		// Reset in mid-run clears every timer register bit
		apb(1'b1, PMD_OFS_TMR, 32'hFF, 4'hF, rd, er);
		settle();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		settle();
		chk("reset clears lines", {24'h0, outv(1)}, 32'h0);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		apb(1'b0, PMD_OFS_TMR, 32'h0, 4'hF, rd, er);
		chk("reset clears reg", rd, 32'h0);
		$display("test mid reset done");
		wrap_up();
	end
endmodule
